//--- design/ltc_line_ctrl.sv
/*
 File: network-side controller that drives the operations channel, both scramblers
 and the reset sub-states towards the network termination.
 Assumes: frame slots, tone detection and line coding are handled by neighbouring logic;
 the line receive strobes are framed and come from the same clock.
*/
`timescale 1ns/1ns
module ltc_line_ctrl
  import ltc_pkg::*;
#(
  parameter int RX_RESET_CYCLES = `LTC_RX_RESET_MS * `LTC_CLK_KHZ
) (
  input  wire logic     sys_clk,
  input  wire logic     rst,
  input  wire logic     cmd_valid,
  input  ltc_eoc_frame_t cmd_frame,
  input  wire logic     cmd_abort,
  input  wire logic     start_req,
  input  wire logic     signal_lost,
  input  wire logic     eoc_slot,
  input  ltc_eoc_frame_t eoc_rx,
  input  wire logic     tx_bit_en,
  input  wire logic     tx_bit,
  input  wire logic     rx_bit_en,
  input  wire logic     rx_bit,
  output ltc_eoc_frame_t eoc_tx,
  output logic          tx_line_bit,
  output logic          rx_user_bit,
  output logic          send_wake_tone,
  output logic          corrupt_crc,
  output logic          cmd_busy,
  output logic          cmd_done,
  output logic          cmd_unable,
  output logic          cmd_misaddr,
  output ltc_code_class_t cmd_class,
  output logic          loop_active,
  output logic          far_corrupting,
  output logic          in_reset
);
  typedef enum {ST_FULL_RESET, ST_RX_RESET, ST_WAKE, ST_ACTIVE} ltc_link_t;
  typedef enum {CMD_IDLE, CMD_SEND} ltc_cmd_t;

  ltc_link_t      link;
  ltc_cmd_t       cstate;
  ltc_eoc_frame_t pending;
  logic [1:0]     match_cnt;
  logic [1:0]     unable_cnt;
  logic [1:0]     hold_cnt;
  logic [31:0]    rst_timer;
  logic           lost_meta;
  logic           lost_sync;
  logic           scr_out;
  logic           dscr_out;
  logic           confirmed;

  ltc_scrambler #(.TAP(`LTC_TAP_TX), .DESCRAMBLE(1'b0)) u_tx_scr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .bit_en  (tx_bit_en),
    .bit_in  (tx_bit),
    .bit_out (scr_out)
  );

  ltc_scrambler #(.TAP(`LTC_TAP_RX), .DESCRAMBLE(1'b1)) u_rx_dscr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .bit_en  (rx_bit_en),
    .bit_in  (rx_bit),
    .bit_out (dscr_out)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_line_bit <= 1'b0;
      rx_user_bit <= 1'b0;
    end else begin
      tx_line_bit <= scr_out;
      rx_user_bit <= dscr_out;
    end
  end

  // Loss of signal comes from the analogue front end, so it is synchronised.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lost_meta <= 1'b1;
      lost_sync <= 1'b1;
    end else begin
      lost_meta <= signal_lost;
      lost_sync <= lost_meta;
    end
  end

  // The far end resets silently, so our model of it follows the line: we only wake it with a tone.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link      <= ST_FULL_RESET;
      rst_timer <= 32'h0;
    end else begin
      case (link)
        ST_FULL_RESET: begin
          rst_timer <= 32'h0;
          if (start_req)
            link <= ST_WAKE;
        end
        ST_RX_RESET: begin
          // The far end may still hear a tone here, so a request goes straight out.
          if (start_req) begin
            link <= ST_WAKE;
          end else if (rst_timer >= RX_RESET_CYCLES - 1) begin
            link <= ST_FULL_RESET;
          end else begin
            rst_timer <= rst_timer + 32'h1;
          end
        end
        ST_WAKE: begin
          if (!lost_sync)
            link <= ST_ACTIVE;
        end
        ST_ACTIVE: begin
          rst_timer <= 32'h0;
          if (lost_sync)
            link <= ST_RX_RESET;
        end
        default: link <= ST_FULL_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      send_wake_tone <= 1'b0;
      in_reset       <= 1'b1;
    end else begin
      send_wake_tone <= (link == ST_WAKE) && lost_sync;
      in_reset       <= (link == ST_FULL_RESET) || (link == ST_RX_RESET);
    end
  end

  assign confirmed = (eoc_rx == pending);

  // The command repeats on every slot until three matching echoes, three refusals or three unconfirmed hold replies come back, or an abort or reset ends it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cstate      <= CMD_IDLE;
      pending     <= '0;
      match_cnt   <= 2'h0;
      unable_cnt  <= 2'h0;
      hold_cnt    <= 2'h0;
      cmd_done    <= 1'b0;
      cmd_unable  <= 1'b0;
      cmd_misaddr <= 1'b0;
      cmd_class   <= LTC_CLS_STD;
    end else begin
      cmd_done    <= 1'b0;
      cmd_unable  <= 1'b0;
      cmd_misaddr <= 1'b0;
      case (cstate)
        CMD_IDLE: begin
          if (cmd_valid) begin
            pending    <= cmd_frame;
            cmd_class  <= ltc_classify(cmd_frame.info);
            match_cnt  <= 2'h0;
            unable_cnt <= 2'h0;
            hold_cnt   <= 2'h0;
            cstate     <= CMD_SEND;
          end
        end
        CMD_SEND: begin
          if (cmd_abort || in_reset) begin
            cstate <= CMD_IDLE;
          end else if (eoc_slot) begin
            match_cnt  <= confirmed ? match_cnt + 2'h1 : 2'h0;
            unable_cnt <= (eoc_rx.is_msg && eoc_rx.info == `LTC_EOC_UNABLE) ? unable_cnt + 2'h1 : 2'h0;
            hold_cnt   <= (eoc_rx.addr == `LTC_ADDR_NT && eoc_rx.info == `LTC_EOC_HOLD && !confirmed)
                          ? hold_cnt + 2'h1 : 2'h0;
            if (confirmed && match_cnt == `LTC_EOC_REPEATS - 2'h1) begin
              cmd_done <= 1'b1;
              cstate   <= CMD_IDLE;
            end else if (unable_cnt == `LTC_EOC_REPEATS - 2'h1 && eoc_rx.info == `LTC_EOC_UNABLE) begin
              cmd_unable <= 1'b1;
              cstate     <= CMD_IDLE;
            end else if (hold_cnt == `LTC_EOC_REPEATS - 2'h1 && eoc_rx.info == `LTC_EOC_HOLD && !confirmed) begin
              cmd_misaddr <= 1'b1;
              cstate      <= CMD_IDLE;
            end
          end
        end
        default: cstate <= CMD_IDLE;
      endcase
    end
  end

  // When idle we send hold, which leaves everything latched at the far end untouched.
  always_ff @(posedge sys_clk) begin
    if (rst)
      eoc_tx <= '{addr: `LTC_ADDR_NT, is_msg: 1'b1, info: `LTC_EOC_HOLD};
    else if (cstate == CMD_SEND)
      eoc_tx <= pending;
    else
      eoc_tx <= '{addr: `LTC_ADDR_NT, is_msg: 1'b1, info: `LTC_EOC_HOLD};
  end

  always_ff @(posedge sys_clk) begin
    cmd_busy <= !rst && (cstate == CMD_SEND);
  end

  // Latched far-end actions, mirrored from confirmed commands; any reset passage clears them.
  always_ff @(posedge sys_clk) begin
    if (rst || in_reset) begin
      loop_active    <= 1'b0;
      far_corrupting <= 1'b0;
      corrupt_crc    <= 1'b0;
    end else if (cmd_done && pending.is_msg) begin
      case (pending.info)
        `LTC_EOC_RETURN_NORMAL: begin
          loop_active    <= 1'b0;
          far_corrupting <= 1'b0;
          corrupt_crc    <= 1'b0;
        end
        `LTC_EOC_FULL_LOOP, `LTC_EOC_B1_LOOP, `LTC_EOC_B2_LOOP: loop_active <= 1'b1;
        `LTC_EOC_REQ_CORRUPT:    far_corrupting <= 1'b1;
        `LTC_EOC_NOTIFY_CORRUPT: corrupt_crc    <= 1'b1;
        default: corrupt_crc <= corrupt_crc;
      endcase
    end
  end

  a_rx_reset_min: assert property (@(posedge sys_clk) disable iff (rst)
    (link == ST_RX_RESET && rst_timer < RX_RESET_CYCLES - 1 && !start_req) |=> link != ST_FULL_RESET)
    else $error("left receive reset early");
  a_reset_silent: assert property (@(posedge sys_clk) disable iff (rst)
    (link == ST_FULL_RESET && !start_req) |=> !send_wake_tone) else $error("tone without request");
  a_done_after_three: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(cmd_done) |-> $past(match_cnt) == 2'h2) else $error("done without three echoes");
  a_rtn_clears: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_done && pending.is_msg && pending.info == `LTC_EOC_RETURN_NORMAL) |=> !corrupt_crc && !loop_active)
    else $error("return to normal left actions latched");
  a_idle_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (cstate == CMD_IDLE) |=> eoc_tx.info == `LTC_EOC_HOLD) else $error("idle slot not hold");
  a_reset_release: assert property (@(posedge sys_clk) disable iff (rst)
    in_reset |=> !loop_active && !far_corrupting) else $error("actions kept through reset");
  a_notify_corrupt: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_done && pending.is_msg && pending.info == `LTC_EOC_NOTIFY_CORRUPT && !in_reset) |=> corrupt_crc)
    else $error("corrupt crc not started");
  a_unable_three: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(cmd_unable) |-> $past(unable_cnt) == 2'h2) else $error("unable without three replies");
endmodule : ltc_line_ctrl

//--- design/ltc_pkg.sv
/*
 File: types shared by the line-termination end controller.
 Assumes: the constants header sits beside it in design/.
*/
`include "ltc_regs.svh"
package ltc_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic       is_msg;
    logic [7:0] info;
  } ltc_eoc_frame_t;
  typedef enum logic [1:0] {LTC_CLS_STD, LTC_CLS_NONSTD, LTC_CLS_NETWORK, LTC_CLS_FUTURE} ltc_code_class_t;
  function automatic ltc_code_class_t ltc_classify(input logic [7:0] code);
    case (code[7:4])
      4'h1, 4'h2, 4'h3, 4'h4: ltc_classify = LTC_CLS_NONSTD;
      4'h6, 4'h7, 4'h8, 4'h9: ltc_classify = LTC_CLS_NETWORK;
      default: begin
        if (code == `LTC_EOC_RETURN_NORMAL || code == `LTC_EOC_HOLD || code == `LTC_EOC_UNABLE ||
            (code >= `LTC_EOC_FULL_LOOP && code <= `LTC_EOC_NOTIFY_CORRUPT))
          ltc_classify = LTC_CLS_STD;
        else
          ltc_classify = LTC_CLS_FUTURE;
      end
    endcase
  endfunction : ltc_classify
endpackage : ltc_pkg

//--- design/ltc_regs.svh
/*
 File: constants for the line-termination end controller: operations-channel codes,
 addresses, frame layout, scrambler taps and reset timing.
 Assumes: included by the package, the bench and the network-termination model by its bare name.
*/
`ifndef LTC_REGS_SVH
`define LTC_REGS_SVH
`define LTC_EOC_RETURN_NORMAL   8'hff
`define LTC_EOC_FULL_LOOP       8'h50
`define LTC_EOC_B1_LOOP         8'h51
`define LTC_EOC_B2_LOOP         8'h52
`define LTC_EOC_REQ_CORRUPT     8'h53
`define LTC_EOC_NOTIFY_CORRUPT  8'h54
`define LTC_EOC_HOLD            8'h00
`define LTC_EOC_UNABLE          8'haa
`define LTC_ADDR_NT             3'h0
`define LTC_ADDR_BCAST          3'h7
`define LTC_EOC_BITS            12
`define LTC_EOC_REPEATS         2'h3
`define LTC_SCR_ORDER           23
`define LTC_TAP_TX              5
`define LTC_TAP_RX              18
`define LTC_SCR_SEED            23'h000001
`define LTC_RX_RESET_MS         40
`define LTC_CLK_KHZ             50000
`endif

//--- design/ltc_scrambler.sv
/*
 File: self-synchronising 23rd-order scrambler or descrambler, one bit per enable.
 Assumes: bit_en marks payload bits; frame word bits arrive with bit_en low.
*/
`timescale 1ns/1ns
module ltc_scrambler
  import ltc_pkg::*;
#(
  parameter int TAP        = `LTC_TAP_TX,
  parameter bit DESCRAMBLE = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic bit_en,
  input  wire logic bit_in,
  output logic      bit_out
);
  logic [`LTC_SCR_ORDER-1:0] shreg;
  logic                      next_out;

  assign next_out = bit_in ^ shreg[TAP-1] ^ shreg[`LTC_SCR_ORDER-1];

  // The seed is never all ones, so idle streams of ones still come out random.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shreg <= `LTC_SCR_SEED;
    end else if (bit_en) begin
      // A scrambler feeds back its output; a descrambler shifts the received line bit.
      shreg <= {shreg[`LTC_SCR_ORDER-2:0], DESCRAMBLE ? bit_in : next_out};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      bit_out <= 1'b0;
    else if (bit_en)
      bit_out <= next_out;
  end

  a_hold_on_frame: assert property (@(posedge sys_clk) disable iff (rst)
    !bit_en |=> $stable(shreg)) else $error("shift register moved during frame word");
  a_never_all_ones: assert property (@(posedge sys_clk) disable iff (rst)
    (DESCRAMBLE || shreg != '1)) else $error("scrambler reached all ones");
endmodule : ltc_scrambler

//--- sim/ltc_line_ctrl_tb_top.sv
/*
 Self-checking bench for the line controller facing the network-termination model.
 Assumes: design package and header compiled first; reset count shortened to 20 cycles.
*/
`timescale 1ns/1ns
`include "ltc_regs.svh"
`define LTC_TB_CHK(what, exp, seen) begin n_tests++; if ((seen) !== (exp)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", what, exp, seen); end end
module ltc_line_ctrl_tb_top;
  import ltc_pkg::*;
  localparam ltc_eoc_frame_t HOLD_F = {`LTC_ADDR_NT, 1'b1, `LTC_EOC_HOLD};
  logic sys_clk, rst, cmd_valid, cmd_abort, start_req, signal_lost, tx_bit_en, tx_bit, eoc_slot, rx_bit_en;
  logic rx_bit, tx_line_bit, rx_user_bit, send_wake_tone, corrupt_crc, cmd_busy, cmd_done, cmd_unable;
  logic cmd_misaddr, loop_active, far_corrupting, in_reset, rec_bit, loop_on, crc_bad, chk_on;
  logic p1_en, p1_bit, p2_en, p2_bit;
  ltc_eoc_frame_t  cmd_frame, eoc_rx, eoc_tx;
  ltc_code_class_t cmd_class;
  int              failures, n_tests, cycles, nbits;
  ltc_line_ctrl #(.RX_RESET_CYCLES(20)) i_ltc_line_ctrl (.sys_clk, .rst, .cmd_valid, .cmd_frame,
    .cmd_abort, .start_req, .signal_lost, .eoc_slot, .eoc_rx, .tx_bit_en, .tx_bit, .rx_bit_en, .rx_bit,
    .eoc_tx, .tx_line_bit, .rx_user_bit, .send_wake_tone, .corrupt_crc, .cmd_busy, .cmd_done, .cmd_unable,
    .cmd_misaddr, .cmd_class, .loop_active, .far_corrupting, .in_reset);
  ltc_nt_model i_ltc_nt_model (.sys_clk, .rst, .link_down(in_reset), .eoc_tx, .user_en(tx_bit_en),
    .user_bit(tx_bit), .line_en(tx_bit_en), .line_bit(tx_line_bit), .eoc_rx, .eoc_slot, .rx_bit_en,
    .rx_bit, .rec_bit, .loop_on, .crc_bad);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // A hung handshake would otherwise stall the run for ever.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  // Both directions share one stimulus, so both recovered streams must equal it two cycles on.
  always @(posedge sys_clk) begin
    if (chk_on && p2_en) begin
      if (nbits >= 24) begin
        `LTC_TB_CHK("line descrambled", p2_bit, rec_bit)
        `LTC_TB_CHK("user descrambled", p2_bit, rx_user_bit)
      end
      nbits++;
    end
    p1_en <= tx_bit_en;
    p1_bit <= tx_bit;
    p2_en <= p1_en;
    p2_bit <= p1_bit;
  end
  function automatic ltc_code_class_t exp_class(input logic [7:0] c);
    if (c[7:4] inside {[4'h1:4'h4]}) return LTC_CLS_NONSTD;
    if (c[7:4] inside {[4'h6:4'h9]}) return LTC_CLS_NETWORK;
    if (c inside {8'hff, 8'h00, 8'haa, [8'h50:8'h54]}) return LTC_CLS_STD;
    return LTC_CLS_FUTURE;
  endfunction : exp_class
  task automatic check_mirrors(input logic [2:0] exp);
    // Mirrors follow the done pulse or the reset entry by one cycle.
    @(posedge sys_clk);
    #1;
    `LTC_TB_CHK("mirrors", exp, {loop_active, far_corrupting, corrupt_crc})
    `LTC_TB_CHK("far latches", exp[2:1], {loop_on, crc_bad})
  endtask : check_mirrors
  task automatic wait_sig(input bit pick_reset, input logic want, input string what);
    logic seen;
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      #1;
      seen = pick_reset ? in_reset : send_wake_tone;
      if (seen === want) break;
    end
    `LTC_TB_CHK(what, want, seen)
  endtask : wait_sig
  // At cycle at, either abort or push a second request that must be ignored.
  task automatic run_cmd(input ltc_eoc_frame_t f, input logic [2:0] exp, input int at, input bit abort);
    logic [2:0] res;
    res = 3'h0;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_frame <= f;
    for (int i = 0; i < 300 && res == 3'h0; i++) begin
      @(posedge sys_clk);
      cmd_valid <= (i == at) && !abort;
      cmd_abort <= (i == at) && abort;
      if (i == at) cmd_frame <= {3'h0, 1'b1, `LTC_EOC_RETURN_NORMAL};
      #1;
      if (i == 1) begin
        `LTC_TB_CHK("frame", f, eoc_tx)
        `LTC_TB_CHK("busy", 1'b1, cmd_busy)
      end
      res = {cmd_done, cmd_unable, cmd_misaddr};
    end
    `LTC_TB_CHK("result", exp, res)
    `LTC_TB_CHK("class", exp_class(f.info), cmd_class)
  endtask : run_cmd
  initial begin
    logic [7:0] odd [5];
    int flips;
    logic last_line;
    odd = '{8'h51, 8'h52, 8'h41, 8'h65, 8'ha0};
    {rst, signal_lost} = 2'b11;
    {cmd_valid, cmd_abort, start_req, tx_bit_en, tx_bit, chk_on, p1_en, p1_bit, p2_en, p2_bit} = '0;
    cmd_frame = HOLD_F;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    `LTC_TB_CHK("idle frame", HOLD_F, eoc_tx)
    wait_sig(1, 1'b1, "power-up reset");
    repeat (20) @(posedge sys_clk);
    #1;
    `LTC_TB_CHK("no tone", 1'b0, send_wake_tone)
    start_req <= 1'b1;
    @(posedge sys_clk);
    start_req <= 1'b0;
    wait_sig(0, 1'b1, "wake tone");
    signal_lost <= 1'b0;
    wait_sig(1, 1'b0, "link up");
    run_cmd({3'h0, 1'b1, `LTC_EOC_FULL_LOOP}, 3'b100, -1, 0);
    check_mirrors(3'b100);
    run_cmd({3'h7, 1'b1, `LTC_EOC_REQ_CORRUPT}, 3'b100, -1, 0);
    check_mirrors(3'b110);
    run_cmd({3'h0, 1'b1, `LTC_EOC_NOTIFY_CORRUPT}, 3'b100, -1, 0);
    run_cmd({3'h0, 1'b1, `LTC_EOC_HOLD}, 3'b100, -1, 0);
    check_mirrors(3'b111);
    run_cmd({3'h3, 1'b1, `LTC_EOC_FULL_LOOP}, 3'b001, -1, 0);
    foreach (odd[i]) run_cmd({3'h0, 1'b1, odd[i]}, 3'b010, -1, 0);
    check_mirrors(3'b111);
    run_cmd({3'h0, 1'b1, `LTC_EOC_RETURN_NORMAL}, 3'b100, -1, 0);
    check_mirrors(3'b000);
    run_cmd({3'h0, 1'b1, `LTC_EOC_FULL_LOOP}, 3'b100, 3, 0);
    run_cmd({3'h0, 1'b1, `LTC_EOC_REQ_CORRUPT}, 3'b000, 2, 1);
    `LTC_TB_CHK("abort idle", HOLD_F, eoc_tx)
    check_mirrors(3'b100);
    flips = 0;
    chk_on = 1'b1;
    for (int i = 0; i < 240; i++) begin
      @(posedge sys_clk);
      tx_bit_en <= (i % 12) >= 2;
      tx_bit <= (i >= 120 && i < 200) ? 1'b1 : ^(i * 37 + (i >> 3));
      if (i > 130 && i < 200 && tx_line_bit !== last_line) flips++;
      last_line = tx_line_bit;
    end
    @(posedge sys_clk);
    tx_bit_en <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_on = 1'b0;
    `LTC_TB_CHK("ones scrambled", 1'b1, flips > 10)
    signal_lost <= 1'b1;
    wait_sig(1, 1'b1, "receive reset");
    check_mirrors(3'b000);
    repeat (60) begin
      @(posedge sys_clk);
      #1;
      `LTC_TB_CHK("silent reset", 2'b01, {send_wake_tone, in_reset})
    end
    @(posedge sys_clk);
    start_req <= 1'b1;
    @(posedge sys_clk);
    start_req <= 1'b0;
    wait_sig(0, 1'b1, "rewake tone");
    complete_run();
  end
endmodule : ltc_line_ctrl_tb_top

//--- sim/ltc_nt_model.sv
/*
 Model of the network-termination end: answers operations-channel frames, keeps latched
 actions, scrambles its user stream and descrambles the controller's line stream.
 Assumes: one clock shared with the controller; a frame slot every SLOT_CYCLES cycles.
*/
`timescale 1ns/1ns
`include "ltc_regs.svh"
module ltc_nt_model
  import ltc_pkg::*;
#(
  parameter int          SLOT_CYCLES = 8,
  parameter logic [22:0] SEED        = 23'h000001
) (
  input  wire logic      sys_clk,
  input  wire logic      rst,
  input  wire logic      link_down,
  input  ltc_eoc_frame_t eoc_tx,
  input  wire logic      user_en,
  input  wire logic      user_bit,
  input  wire logic      line_en,
  input  wire logic      line_bit,
  output ltc_eoc_frame_t eoc_rx,
  output logic           eoc_slot,
  output logic           rx_bit_en,
  output logic           rx_bit,
  output logic           rec_bit,
  output logic           loop_on,
  output logic           crc_bad
);
  localparam ltc_eoc_frame_t HOLD_F = {`LTC_ADDR_NT, 1'b1, `LTC_EOC_HOLD};
  logic [22:0]    scr;
  logic [22:0]    dscr;
  logic [7:0]     slot_cnt;
  logic [1:0]     rep;
  logic [1:0]     en_pipe;
  ltc_eoc_frame_t last;
  logic           addressed;
  logic           known;
  logic           same;
  logic           slot;
  assign slot      = slot_cnt == 8'(SLOT_CYCLES - 1);
  assign addressed = eoc_tx.addr == `LTC_ADDR_NT || eoc_tx.addr == `LTC_ADDR_BCAST;
  // Single-channel loops are optional; this end declines them like any unknown code.
  assign known = eoc_tx.is_msg && eoc_tx.info inside {`LTC_EOC_FULL_LOOP, `LTC_EOC_REQ_CORRUPT,
    `LTC_EOC_NOTIFY_CORRUPT, `LTC_EOC_RETURN_NORMAL, `LTC_EOC_HOLD};
  assign same = eoc_tx == last;
  always_ff @(posedge sys_clk) begin
    eoc_slot <= 1'b0;
    slot_cnt <= (rst || slot) ? 8'h00 : slot_cnt + 8'h01;
    if (rst) begin
      rep    <= 2'h0;
      last   <= HOLD_F;
      eoc_rx <= HOLD_F;
    end else if (slot) begin
      eoc_slot <= 1'b1;
      last     <= eoc_tx;
      rep      <= !same ? 2'h1 : (rep == 2'h3 ? rep : rep + 2'h1);
      if (!addressed)
        eoc_rx <= HOLD_F;
      else if (!known && same && rep >= 2'h2)
        eoc_rx <= {`LTC_ADDR_NT, 1'b1, `LTC_EOC_UNABLE};
      else
        eoc_rx <= eoc_tx;
    end
  end
  // Hold and notify leave both latches as they are.
  always_ff @(posedge sys_clk) begin
    if (rst || link_down) begin
      loop_on <= 1'b0;
      crc_bad <= 1'b0;
    end else if (slot && addressed && known && same && rep == 2'h2) begin
      if (eoc_tx.info == `LTC_EOC_RETURN_NORMAL) begin
        loop_on <= 1'b0;
        crc_bad <= 1'b0;
      end
      if (eoc_tx.info == `LTC_EOC_FULL_LOOP)
        loop_on <= 1'b1;
      if (eoc_tx.info == `LTC_EOC_REQ_CORRUPT)
        crc_bad <= 1'b1;
    end
  end
  assign rx_bit_en = user_en;
  assign rx_bit    = user_bit ^ scr[17] ^ scr[22];
  assign rec_bit   = line_bit ^ dscr[4] ^ dscr[22];
  always_ff @(posedge sys_clk) begin
    if (rst)
      scr <= SEED;
    else if (user_en)
      scr <= {scr[21:0], rx_bit};
  end
  always_ff @(posedge sys_clk) begin
    en_pipe <= {en_pipe[0], line_en};
    if (rst)
      dscr <= 23'h000000;
    else if (en_pipe[1])
      dscr <= {dscr[21:0], line_bit};
  end
endmodule : ltc_nt_model
